// ===== logic/ppo_port_top.sv
// port a pin override, register bits, input routing and function map
`timescale 1ns/1ps
module ppo_port_top (
    // clock, reset, enable
    input  wire logic                       core_clk,
    input  wire logic                       nrst,
    input  wire logic                       ce,
    // shared controls
    input  wire logic                       global_pullup_disable,
    input  wire logic                       sleep_clamp,
    // port register strobes
    input  wire logic [ppo_pkg::PORT_W-1:0] wr_data,
    input  wire logic                       wr_direction,
    input  wire logic                       wr_latch,
    input  wire logic                       wr_pin,
    input  wire logic                       rd_direction,
    input  wire logic                       rd_latch,
    input  wire logic                       rd_pin,
    output logic      [ppo_pkg::PORT_W-1:0] rd_data_q,
    // register state
    output logic      [ppo_pkg::PORT_W-1:0] direction_bit_q,
    output logic      [ppo_pkg::PORT_W-1:0] output_latch_bit_q,
    output logic      [ppo_pkg::PORT_W-1:0] pin_sample_bit_q,
    // per-pin overrides
    input  wire logic [ppo_pkg::PORT_W-1:0] pull_up_override_enable,
    input  wire logic [ppo_pkg::PORT_W-1:0] pull_up_override_value,
    input  wire logic [ppo_pkg::PORT_W-1:0] direction_override_enable,
    input  wire logic [ppo_pkg::PORT_W-1:0] direction_override_value,
    input  wire logic [ppo_pkg::PORT_W-1:0] out_level_override_enable,
    input  wire logic [ppo_pkg::PORT_W-1:0] out_level_override_value,
    input  wire logic [ppo_pkg::PORT_W-1:0] latch_toggle_override_enable,
    input  wire logic [ppo_pkg::PORT_W-1:0] input_gate_override_enable,
    input  wire logic [ppo_pkg::PORT_W-1:0] input_gate_override_value,
    // digital pad
    input  wire logic [ppo_pkg::PORT_W-1:0] pad_in,
    output logic      [ppo_pkg::PORT_W-1:0] pad_out,
    output logic      [ppo_pkg::PORT_W-1:0] pad_oe,
    output logic      [ppo_pkg::PORT_W-1:0] pad_pull_up,
    output logic      [ppo_pkg::PORT_W-1:0] pad_input_en,
    // analog pad and module side
    input  wire logic [ppo_pkg::PORT_W-1:0] analog_pad_in,
    output logic      [ppo_pkg::PORT_W-1:0] analog_pad_out,
    output logic      [ppo_pkg::PORT_W-1:0] analog_pad_oe,
    input  wire logic [ppo_pkg::PORT_W-1:0] analog_drive_level,
    input  wire logic [ppo_pkg::PORT_W-1:0] analog_drive_en,
    output logic      [ppo_pkg::PORT_W-1:0] analog_pass_path,
    // raw inputs to alternate functions
    output logic      [ppo_pkg::PORT_W-1:0] alt_raw_input,
    output logic      [ppo_pkg::PORT_W-1:0] pin_change_source,
    output logic      [ppo_pkg::PORT_W-1:0] converter_channel,
    // function map taps
    output logic                            analog_reference_in,
    output logic                            comparator_pos_in,
    output logic                            comparator_neg_in,
    output logic                            timer0_ext_clock,
    output logic                            timer1_ext_clock,
    output logic                            shifter_clock,
    output logic                            shifter_data_in,
    output logic                            spi_mosi_in,
    output logic                            spi_miso_in,
    output logic                            timer1_capture_in,
    output logic                            timer1_match_b_out,
    output logic                            timer1_match_a_out,
    output logic                            timer0_match_b_out
);
    import ppo_pkg::*;

    // ---------------------------------------------------------------
    // reset release
    // ---------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n;

    // async assert, release through two flops so every flop on rst_n leaves reset together
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n      <= rst_meta_q;
        end
    end

    // ---------------------------------------------------------------
    // decode helpers
    // ---------------------------------------------------------------
    // read select, used only by the read register; the checks decode the strobes directly
    function automatic ppo_rd_sel_t rd_sel(input logic d, input logic l, input logic p);
        ppo_rd_sel_t s;
        s = PPO_RD_NONE;
        if (d) begin
            s = PPO_RD_DIR;
        end else if (l) begin
            s = PPO_RD_LATCH;
        end else if (p) begin
            s = PPO_RD_PIN;
        end
        return s;
    endfunction

    // next latch value: write, then software toggle, then override toggle
    function automatic logic [PORT_W-1:0] latch_next(input logic [PORT_W-1:0] cur,
                                                     input logic              wl,
                                                     input logic              wp,
                                                     input logic [PORT_W-1:0] dat,
                                                     input logic [PORT_W-1:0] tog);
        logic [PORT_W-1:0] v;
        v = wl ? dat : cur;
        v = v ^ (wp ? dat : '0);
        return v ^ tog;
    endfunction

    // ---------------------------------------------------------------
    // port register bits
    // ---------------------------------------------------------------
    // direction register: one makes the pin an output
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            direction_bit_q <= DIRECTION_RST;
        end else if (ce && wr_direction) begin
            direction_bit_q <= wr_data;
        end
    end

    // output latch; a toggle held high inverts once per enabled cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            output_latch_bit_q <= LATCH_RST;
        end else if (ce) begin
            output_latch_bit_q <= latch_next(output_latch_bit_q, wr_latch, wr_pin,
                                             wr_data, latch_toggle_override_enable);
        end
    end

    // ---------------------------------------------------------------
    // per-pin override cells
    // ---------------------------------------------------------------
    logic [PORT_W-1:0] drive_en;
    logic [PORT_W-1:0] drive_level;
    logic [PORT_W-1:0] input_en;
    logic [PORT_W-1:0] pull_up_en;
    logic [PORT_W-1:0] gated_in;

    // shared controls fan out, each register and override bit stays private
    for (genvar i = 0; i < PORT_W; i++) begin : g_pin
        ppo_pin_cell u_cell (
            .direction_bit              (direction_bit_q[i]),
            .output_latch_bit           (output_latch_bit_q[i]),
            .global_pullup_disable      (global_pullup_disable),
            .sleep_clamp                (sleep_clamp),
            .pull_up_override_enable    (pull_up_override_enable[i]),
            .pull_up_override_value     (pull_up_override_value[i]),
            .direction_override_enable  (direction_override_enable[i]),
            .direction_override_value   (direction_override_value[i]),
            .out_level_override_enable  (out_level_override_enable[i]),
            .out_level_override_value   (out_level_override_value[i]),
            .input_gate_override_enable (input_gate_override_enable[i]),
            .input_gate_override_value  (input_gate_override_value[i]),
            .pad_in                     (pad_in[i]),
            .pull_up_en                 (pull_up_en[i]),
            .drive_en                   (drive_en[i]),
            .drive_level                (drive_level[i]),
            .input_en                   (input_en[i]),
            .gated_in                   (gated_in[i])
        );
    end

    // pad controls stay combinational so an override takes the pin at once
    always_comb begin
        pad_oe       = drive_en;
        pad_out      = drive_level;
        pad_pull_up  = pull_up_en;
        pad_input_en = input_en;
    end

    // ---------------------------------------------------------------
    // input paths
    // ---------------------------------------------------------------
    // raw input is before the synchronizer; receivers synchronize it themselves
    always_comb begin
        alt_raw_input     = gated_in;
        pin_change_source = gated_in;
    end

    // sampled copy for the pin register
    ppo_sync2 u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .d        (gated_in),
        .q        (pin_sample_bit_q)
    );

    // analog path bypasses all digital gating, in both directions
    always_comb begin
        analog_pass_path  = analog_pad_in;
        converter_channel = analog_pad_in;
        analog_pad_out    = analog_drive_level;
        analog_pad_oe     = analog_drive_en;
    end

    // ---------------------------------------------------------------
    // function map
    // ---------------------------------------------------------------
    // analog functions
    always_comb begin
        analog_reference_in = analog_pad_in[PIN_ANALOG_REFERENCE_IN];
        comparator_pos_in   = analog_pad_in[PIN_CMP_POS];
        comparator_neg_in   = analog_pad_in[PIN_CMP_NEG];
    end

    // clock and data inputs; clock users take the raw level unsynchronized
    always_comb begin
        timer0_ext_clock  = gated_in[PIN_T0_CLK];
        shifter_clock     = gated_in[PIN_SHF_CLK];
        timer1_ext_clock  = gated_in[PIN_T1_CLK];
        spi_miso_in       = gated_in[PIN_SPI_MISO];
        shifter_data_in   = gated_in[PIN_SHF_DI];
        spi_mosi_in       = gated_in[PIN_SPI_MOSI];
        timer1_capture_in = gated_in[PIN_T1_CAP];
    end

    // compare outputs reach their pin as the level override value; this shows
    // the level actually presented there
    always_comb begin
        timer1_match_b_out = pad_out[PIN_T1_MB];
        timer1_match_a_out = pad_out[PIN_T1_MA];
        timer0_match_b_out = pad_out[PIN_T0_MB];
    end

    // ---------------------------------------------------------------
    // register read port
    // ---------------------------------------------------------------
    // one read register shared by the three port strobes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= RD_DATA_RST;
        end else if (ce) begin
            case (rd_sel(rd_direction, rd_latch, rd_pin))
                PPO_RD_DIR:   rd_data_q <= direction_bit_q;
                PPO_RD_LATCH: rd_data_q <= output_latch_bit_q;
                PPO_RD_PIN:   rd_data_q <= pin_sample_bit_q;
                default:      rd_data_q <= rd_data_q;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    pullup_norm_a: assert property (
        pad_pull_up == ((pull_up_override_enable & pull_up_override_value) |
                        (~pull_up_override_enable & ~direction_bit_q & output_latch_bit_q &
                         {PORT_W{!global_pullup_disable}})))
        else $error("pull-up does not match override or latch code");

    pullup_ovr_a: assert property (
        (pull_up_override_enable & (pad_pull_up ^ pull_up_override_value)) == '0)
        else $error("overridden pull-up differs from its value");

    drive_sel_a: assert property (
        (~direction_override_enable & (pad_oe ^ direction_bit_q)) == '0)
        else $error("driver enable does not follow direction bit");

    drive_ovr_a: assert property (
        (direction_override_enable & (pad_oe ^ direction_override_value)) == '0)
        else $error("overridden driver enable differs from its value");

    level_latch_a: assert property (
        (~out_level_override_enable & (pad_out ^ output_latch_bit_q)) == '0)
        else $error("driven level does not follow output latch");

    level_ovr_a: assert property (
        (out_level_override_enable & (pad_out ^ out_level_override_value)) == '0)
        else $error("overridden level differs from its value");

    toggle_flip_a: assert property (
        (rst_n && ce && !wr_latch && !wr_pin) |=>
            output_latch_bit_q == ($past(output_latch_bit_q) ^ $past(latch_toggle_override_enable)))
        else $error("toggle override did not invert the latch");

    input_gate_a: assert property (
        (~input_gate_override_enable & (pad_input_en ^ {PORT_W{!sleep_clamp}})) == '0)
        else $error("input gate does not follow sleep state");

    gate_ovr_a: assert property (
        (input_gate_override_enable & (pad_input_en ^ input_gate_override_value)) == '0)
        else $error("overridden input gate differs from its value");

    sample_delay_a: assert property (
        // both stages must have loaded after reset, else the reset zeros are still in flight
        ($past(rst_n, 2) && $past(ce, 2) && $past(ce, 1)) |-> pin_sample_bit_q == $past(alt_raw_input, 2))
        else $error("pin sample is not the raw input two cycles back");

    clamp_ground_a: assert property (
        sleep_clamp |-> (alt_raw_input & ~input_gate_override_enable) == '0)
        else $error("clamped input is not grounded");

    read_pin_a: assert property (
        (ce && rd_pin && !rd_direction && !rd_latch) |=> rd_data_q == $past(pin_sample_bit_q))
        else $error("pin read returned wrong data");

    freeze_a: assert property (
        !ce |=> $stable(direction_bit_q) && $stable(output_latch_bit_q))
        else $error("state changed while clock enable low");

    toggle_cov_c: cover property (ce && latch_toggle_override_enable != '0 && !wr_latch);
    sleep_ovr_c:  cover property (sleep_clamp && (input_gate_override_enable & input_gate_override_value) != '0);
    drive_ovr_c:  cover property (direction_override_enable != '0 ##1 direction_override_enable == '0);
    pullup_c:     cover property (pad_pull_up != '0 && !global_pullup_disable);

endmodule

// ===== logic/ppo_pkg.sv
// shared constants for the port a pin override block
package ppo_pkg;

    // ---------------------------------------------------------------
    // port geometry
    // ---------------------------------------------------------------
    localparam int unsigned PORT_W = 8;

    // ---------------------------------------------------------------
    // reset values of the port register bits
    // ---------------------------------------------------------------
    localparam logic [PORT_W-1:0] DIRECTION_RST = 8'h00;
    localparam logic [PORT_W-1:0] LATCH_RST     = 8'h00;
    localparam logic [PORT_W-1:0] SAMPLE_RST    = 8'h00;
    localparam logic [PORT_W-1:0] RD_DATA_RST   = 8'h00;

    // ---------------------------------------------------------------
    // pull-up condition {direction, latch, pullup disable}
    // ---------------------------------------------------------------
    localparam logic [2:0] PULLUP_ON_CODE = 3'h2;

    // ---------------------------------------------------------------
    // timing: synchronizer depth in clock cycles
    // ---------------------------------------------------------------
    localparam int unsigned SYNC_STAGES = 2;

    // ---------------------------------------------------------------
    // pin positions of the shared functions on port a
    // ---------------------------------------------------------------
    localparam int unsigned PIN_ANALOG_REFERENCE_IN     = 0;
    localparam int unsigned PIN_CMP_POS  = 1;
    localparam int unsigned PIN_CMP_NEG  = 2;
    localparam int unsigned PIN_T0_CLK   = 3;
    localparam int unsigned PIN_SHF_CLK  = 4;
    localparam int unsigned PIN_T1_CLK   = 4;
    localparam int unsigned PIN_SHF_DO   = 5;
    localparam int unsigned PIN_SPI_MISO = 5;
    localparam int unsigned PIN_T1_MB    = 5;
    localparam int unsigned PIN_SHF_DI   = 6;
    localparam int unsigned PIN_SPI_MOSI = 6;
    localparam int unsigned PIN_T1_MA    = 6;
    localparam int unsigned PIN_T0_MB    = 7;
    localparam int unsigned PIN_T1_CAP   = 7;

    // ---------------------------------------------------------------
    // register read selection
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        PPO_RD_NONE,
        PPO_RD_DIR,
        PPO_RD_LATCH,
        PPO_RD_PIN
    } ppo_rd_sel_t;

endpackage

// ===== logic/ppo_sync2.sv
// two-stage synchronizer for the port sample path
`timescale 1ns/1ps
module ppo_sync2 (
    // clock, reset, enable
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    // data
    input  wire logic [ppo_pkg::PORT_W-1:0] d,
    output logic      [ppo_pkg::PORT_W-1:0] q
);
    import ppo_pkg::*;

    logic [PORT_W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= SAMPLE_RST;
            q      <= SAMPLE_RST;
        end else if (ce) begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule

// ===== logic/ppo_pin_cell.sv
// combinational override selection for one port pin
`timescale 1ns/1ps
module ppo_pin_cell (
    // port register bits and shared controls
    input  wire logic direction_bit,
    input  wire logic output_latch_bit,
    input  wire logic global_pullup_disable,
    input  wire logic sleep_clamp,
    // overrides from the owning peripheral
    input  wire logic pull_up_override_enable,
    input  wire logic pull_up_override_value,
    input  wire logic direction_override_enable,
    input  wire logic direction_override_value,
    input  wire logic out_level_override_enable,
    input  wire logic out_level_override_value,
    input  wire logic input_gate_override_enable,
    input  wire logic input_gate_override_value,
    // pad side
    input  wire logic pad_in,
    output logic      pull_up_en,
    output logic      drive_en,
    output logic      drive_level,
    output logic      input_en,
    output logic      gated_in
);
    import ppo_pkg::*;

    // pure selection, no state: a change of enable acts in the same cycle
    always_comb begin
        pull_up_en = pull_up_override_enable ? pull_up_override_value
                   : ({direction_bit, output_latch_bit, global_pullup_disable} == PULLUP_ON_CODE);
        drive_en   = direction_override_enable ? direction_override_value : direction_bit;
        // level only matters while the driver is on
        drive_level = out_level_override_enable ? out_level_override_value : output_latch_bit;
        input_en   = input_gate_override_enable ? input_gate_override_value : !sleep_clamp;
        // clamp grounds the schmitt input when the gate is shut
        gated_in   = pad_in & input_en;
    end

endmodule

// ===== dv/ppo_pad_model.sv
// far-side pad model: resolves the pin level seen by the port
`timescale 1ns/1ps
module ppo_pad_model (
    // port side
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pull_up,
    // external circuit
    input  wire logic [7:0] ext_level,
    input  wire logic [7:0] ext_drive,
    output logic      [7:0] pad_in
);
    // an undriven pin without pull-up floats, shown as the inverse level so no stale value passes
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_drive & ext_level)
                  | (~pad_oe & ~ext_drive & (pad_pull_up | ~ext_level));
endmodule

// ===== dv/testbench.sv
// self-checking bench for the port pin override block
`timescale 1ns/1ps
module testbench;
    import ppo_pkg::*;
    logic core_clk = 0, nrst = 0, ce = 1, global_pullup_disable = 0, sleep_clamp = 0, wr_direction = 0;
    logic wr_latch = 0, wr_pin = 0, rd_direction = 0, rd_latch = 0, rd_pin = 0;
    logic [7:0] wr_data = 0, pull_up_override_enable = 0, pull_up_override_value = 0, direction_override_enable = 0;
    logic [7:0] direction_override_value = 0, out_level_override_enable = 0, out_level_override_value = 0;
    logic [7:0] latch_toggle_override_enable = 0, input_gate_override_enable = 0, input_gate_override_value = 0;
    logic [7:0] analog_pad_in = 0, analog_drive_level = 0, analog_drive_en = 0, ext_level = 0, ext_drive = 0;
    logic [7:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_input_en, analog_pad_out, analog_pad_oe, analog_pass_path;
    logic [7:0] alt_raw_input, pin_change_source, converter_channel, rd_data_q;
    logic [7:0] direction_bit_q, output_latch_bit_q, pin_sample_bit_q;
    logic analog_reference_in, comparator_pos_in, comparator_neg_in, timer0_ext_clock, timer1_ext_clock;
    logic shifter_clock, shifter_data_in, spi_mosi_in, spi_miso_in, timer1_capture_in;
    logic timer1_match_b_out, timer1_match_a_out, timer0_match_b_out;
    int failures = 0, tests_run = 0;
    always #10 core_clk = ~core_clk;
    ppo_port_top u_ppo_port_top (.*);
    ppo_pad_model u_ppo_pad_model (.*);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // inputs always move 2 ns after the rising edge
    task automatic step(input int n = 1);
        repeat (n) @(posedge core_clk);
        #2;
    endtask
    task automatic put(input logic [7:0] d, input logic [7:0] l);
        wr_data = d; wr_direction = 1; step();
        wr_data = l; wr_direction = 0; wr_latch = 1; step();
        wr_latch = 0;
    endtask
    task automatic t_pull;
        for (int c = 0; c < 8; c++) begin
            global_pullup_disable = c[0];
            put({8{c[2]}}, {8{c[1]}});
            chk(pad_pull_up, {8{c[2:0] == PULLUP_ON_CODE}});
            chk(pad_oe, {8{c[2]}});
            pull_up_override_enable = 8'hF0; pull_up_override_value = 8'h3C; step();
            chk(pad_pull_up, {4'h3, {4{c[2:0] == PULLUP_ON_CODE}}});
            pull_up_override_enable = 0;
        end
    endtask
    task automatic t_drive;
        put(8'h0F, 8'h55);
        direction_override_enable = 8'hCC; direction_override_value = 8'hA0; step();
        chk(pad_oe, 8'h83);
        chk(pad_out & pad_oe, 8'h01);
        out_level_override_enable = 8'hFF; out_level_override_value = 8'h96; step();
        chk(pad_out & pad_oe, 8'h82);
        direction_override_enable = 8'hFF; direction_override_value = 8'hFF; step();
        chk({5'h0, timer0_match_b_out, timer1_match_a_out, timer1_match_b_out}, 8'h04);
        direction_override_enable = 0; out_level_override_enable = 0;
        latch_toggle_override_enable = 8'h81; step();
        latch_toggle_override_enable = 0;
        chk(output_latch_bit_q, 8'hD4);
    endtask
    task automatic t_input;
        put(8'h00, 8'h00);
        ext_drive = 8'hFF; ext_level = 8'hA5; step();
        chk(alt_raw_input, 8'hA5);
        chk(pin_change_source, 8'hA5);
        chk({timer1_capture_in, spi_mosi_in, spi_miso_in, timer1_ext_clock, timer0_ext_clock,
             shifter_clock, shifter_data_in, 1'b0}, 8'hA0);
        sleep_clamp = 1; step();
        chk(pad_input_en | alt_raw_input, 8'h00);
        input_gate_override_enable = 8'hF0; input_gate_override_value = 8'h30; step();
        chk(pad_input_en, 8'h30);
        chk(alt_raw_input, 8'h20);
        sleep_clamp = 0; input_gate_override_enable = 0; step(3);
        chk(pin_sample_bit_q, 8'hA5);
        analog_pad_in = 8'h6B; analog_drive_en = 8'h0F; analog_drive_level = 8'h09; step();
        chk(analog_pass_path & converter_channel, 8'h6B);
        chk({5'h0, comparator_neg_in, comparator_pos_in, analog_reference_in}, 8'h03);
        chk(analog_pad_oe, 8'h0F);
        chk(analog_pad_out & analog_pad_oe, 8'h09);
    endtask
    // register reads, software toggle and clock-enable freeze; pads still driven A5 from outside
    task automatic t_regs;
        put(8'h3C, 8'hA5);
        wr_data = 8'h0F; wr_pin = 1; step();
        wr_pin = 0; rd_direction = 1; step();
        chk(rd_data_q, 8'h3C);
        rd_direction = 0; rd_latch = 1; step();
        chk(rd_data_q, 8'hAA);
        rd_latch = 0; rd_pin = 1; step();
        chk(rd_data_q, 8'hA9);
        ce = 0; rd_pin = 0; rd_direction = 1; wr_direction = 1; wr_data = 8'hFF; step();
        ce = 1; rd_direction = 0; wr_direction = 0; step();
        chk(direction_bit_q, 8'h3C);
        chk(rd_data_q, 8'hA9);
    endtask
    task automatic close_out;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        step(16);
        nrst = 1;
        step(3);
        t_pull;
        t_drive;
        t_input;
        t_regs;
        close_out;
    end
    // whole run is under 100 cycles, so 20 us means a hang
    initial begin
        #20000;
        failures++;
        close_out;
    end
endmodule
